// ---- verilog/spi_port_pkg.sv ----
// Constants shared by the serial port design
package spi_port_pkg;

    // Register byte addresses
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_DATA = 4'h4;
    localparam logic [3:0] ADDR_CONTROL_ONE = 4'h8;
    localparam logic [3:0] ADDR_CONTROL_TWO = 4'hc;

    // Status bit positions
    localparam int STAT_RECEIVE_FULL = 7;
    localparam int STAT_TRANSMIT_EMPTY = 5;
    localparam int STAT_MODE_FAULT = 4;

    // Control register one bit positions
    localparam int CTL1_RECEIVE_IRQ = 7;
    localparam int CTL1_PORT_ENABLE = 6;
    localparam int CTL1_TRANSMIT_IRQ = 5;
    localparam int CTL1_MASTER_MODE = 4;
    localparam int CTL1_CLOCK_POLARITY = 3;
    localparam int CTL1_CLOCK_PHASE = 2;
    localparam int CTL1_SELECT_OUTPUT = 1;
    localparam int CTL1_BIT_ORDER = 0;

    // Control register two bit positions and implemented bits
    localparam int CTL2_FAULT_DETECT = 4;
    localparam logic [7:0] CTL2_IMPLEMENTED = 8'h1b;

    // Reset values
    localparam logic [7:0] CONTROL_ONE_RESET = 8'h04;
    localparam logic [7:0] CONTROL_TWO_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // Serial timing
    localparam int CLOCK_PERIOD_NS = 25;
    localparam int SCK_HALF_PERIOD_NS = 100;
    localparam int SCK_HALF_CYCLES = (SCK_HALF_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int EDGES_PER_BYTE = 16;

    // Transfer engine states
    typedef enum logic [1:0] {
        ENGINE_IDLE = 2'b01,
        ENGINE_RUN = 2'b10
    } engine_type;

endpackage

// ---- verilog/pin_sync.sv ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pins,
    output logic [WIDTH-1:0] stable
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge clock) begin
        if (rst) begin
            stage1 <= INIT;
            stage2 <= INIT;
            stage3 <= INIT;
            stable <= INIT;
        end else begin
            stage1 <= pins;
            stage2 <= stage1;
            stage3 <= stage2;
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2[i] == stage3[i]) begin
                    stable[i] <= stage3[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- verilog/spi_port.sv ----
// Double-buffered serial port with status flags and byte engine
//
// Notes on behaviour
// - Transfer completion sets receive-full status bit 7.
// - Status read then data read clears receive-full.
// - Transmit-empty bit 5 shows buffer room.
// - Armed data write clears transmit-empty; unarmed ignored.
// - Transmit-empty with its enable raises interrupt.
// - Idle enabled master moves written byte quickly.
// - No queued byte: flag stays, nothing moves.
// - Select low in fault-input mode sets fault.
// - Status read then control-one write clears fault.
// - Unused status bits zero; status writes ignored.
// - Data reads receive buffer, writes transmit buffer.
// - Master starts transfer when shifter is free.
// - Overrun drops new byte without any indication.
// - Sample on one edge, change next edge.
// - Eight clocks move byte into receive buffer.
// - Queued byte loads and next transfer starts.
// - Most significant first unless bit order set.
// - Fault clears master mode and the clock, MOSI and select drivers.
// - Receive enable gates receive-full and fault.
`timescale 1ns/1ps
`default_nettype none
module spi_port
    import spi_port_pkg::*;
#(
    parameter logic [7:0] HALF_CYCLES = 8'(SCK_HALF_CYCLES)
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic irq,
    input wire logic serialClockIn,
    output logic serialClockOut,
    output logic serialClockDriveN,
    input wire logic mosiIn,
    output logic mosiOut,
    output logic mosiDriveN,
    input wire logic misoIn,
    output logic misoOut,
    output logic misoDriveN,
    input wire logic selectIn,
    output logic selectOut,
    output logic selectDriveN
);
    typedef struct packed {
        engine_type engine;
        logic [7:0] control1;
        logic [7:0] control2;
        logic receiveFull;
        logic transmitEmpty;
        logic modeFault;
        logic armReceive;
        logic armTransmit;
        logic armFault;
        logic [7:0] receiveBuffer;
        logic [7:0] transmitBuffer;
        logic [7:0] txShift;
        logic [7:0] rxShift;
        logic [3:0] edgeCount;
        logic sampled;
        logic [7:0] divCount;
        logic sckLevel;
        logic sckPrev;
        logic waitrequest;
        logic [31:0] readdata;
        logic irq;
        logic sckOut;
        logic sckDriveN;
        logic mosiOut;
        logic mosiDriveN;
        logic misoOut;
        logic misoDriveN;
        logic ssOut;
        logic ssDriveN;
    } state_type;

    localparam state_type STATE_RESET = '{
        engine: ENGINE_IDLE,
        control1: CONTROL_ONE_RESET,
        control2: CONTROL_TWO_RESET,
        receiveFull: 1'b0,
        transmitEmpty: 1'b1,
        modeFault: 1'b0,
        armReceive: 1'b0,
        armTransmit: 1'b0,
        armFault: 1'b0,
        receiveBuffer: DATA_RESET,
        transmitBuffer: DATA_RESET,
        txShift: DATA_RESET,
        rxShift: DATA_RESET,
        edgeCount: 4'h0,
        sampled: 1'b0,
        divCount: 8'h00,
        sckLevel: CONTROL_ONE_RESET[CTL1_CLOCK_POLARITY],
        sckPrev: 1'b1,
        waitrequest: 1'b1,
        readdata: 32'h0000_0000,
        irq: 1'b0,
        sckOut: CONTROL_ONE_RESET[CTL1_CLOCK_POLARITY],
        sckDriveN: 1'b1,
        mosiOut: 1'b0,
        mosiDriveN: 1'b1,
        misoOut: 1'b0,
        misoDriveN: 1'b1,
        ssOut: 1'b1,
        ssDriveN: 1'b1
    };

    state_type s;
    state_type next_s;

    logic [3:0] syncPins;
    logic sckSync;
    logic mosiSync;
    logic misoSync;
    logic selectSync;

    pin_sync #(
        .WIDTH(4),
        .INIT(4'hf)
    ) inputSync (
        .clock(clock),
        .rst(rst),
        .pins({serialClockIn, mosiIn, misoIn, selectIn}),
        .stable(syncPins)
    );

    assign sckSync = syncPins[3];
    assign mosiSync = syncPins[2];
    assign misoSync = syncPins[1];
    assign selectSync = syncPins[0];

    // Load shifter from buffer and begin a byte
    function automatic state_type startByte(input state_type st);
        state_type r;
        r = st;
        if (!st.transmitEmpty) begin
            r.txShift = st.transmitBuffer;
        end
        r.transmitEmpty = 1'b1;
        r.engine = ENGINE_RUN;
        r.edgeCount = 4'h0;
        r.sampled = 1'b0;
        r.divCount = 8'h00;
        r.sckLevel = st.control1[CTL1_CLOCK_POLARITY];
        return r;
    endfunction

    always_comb begin
        logic isMaster;
        logic enabled;
        logic cpol;
        logic clock_phase;
        logic lsbFirst;
        logic faultInput;
        logic edgeNow;
        logic leadNow;
        logic inBit;
        logic txBit;
        logic masterDrive;
        logic autoSelect;
        logic busReq;
        isMaster = s.control1[CTL1_MASTER_MODE];
        enabled = s.control1[CTL1_PORT_ENABLE];
        cpol = s.control1[CTL1_CLOCK_POLARITY];
        clock_phase = s.control1[CTL1_CLOCK_PHASE];
        lsbFirst = s.control1[CTL1_BIT_ORDER];
        faultInput = isMaster && s.control2[CTL2_FAULT_DETECT] && !s.control1[CTL1_SELECT_OUTPUT];
        edgeNow = 1'b0;
        leadNow = 1'b0;
        txBit = 1'b0;
        masterDrive = 1'b0;
        autoSelect = 1'b0;
        inBit = isMaster ? misoSync : mosiSync;
        busReq = (read || write) && s.waitrequest;
        next_s = s;
        next_s.sckPrev = sckSync;
        next_s.waitrequest = 1'b1;

        // Register access: one wait cycle, then answer
        if (busReq) begin
            next_s.waitrequest = 1'b0;
            next_s.readdata = 32'h0000_0000;
            unique case (address)
                ADDR_STATUS: begin
                    if (read) begin
                        next_s.readdata[STAT_RECEIVE_FULL] = s.receiveFull;
                        next_s.readdata[STAT_TRANSMIT_EMPTY] = s.transmitEmpty;
                        next_s.readdata[STAT_MODE_FAULT] = s.modeFault;
                        next_s.armReceive = s.receiveFull;
                        next_s.armTransmit = s.transmitEmpty;
                        next_s.armFault = s.modeFault;
                    end
                end
                ADDR_DATA: begin
                    if (read) begin
                        next_s.readdata[7:0] = s.receiveBuffer;
                        if (s.armReceive) begin
                            next_s.receiveFull = 1'b0;
                            next_s.armReceive = 1'b0;
                        end
                    end else if (s.armTransmit) begin
                        next_s.transmitBuffer = writedata[7:0];
                        next_s.transmitEmpty = 1'b0;
                        next_s.armTransmit = 1'b0;
                    end
                end
                ADDR_CONTROL_ONE: begin
                    if (read) begin
                        next_s.readdata[7:0] = s.control1;
                    end else begin
                        next_s.control1 = writedata[7:0];
                        if (s.armFault) begin
                            next_s.modeFault = 1'b0;
                            next_s.armFault = 1'b0;
                        end
                    end
                end
                ADDR_CONTROL_TWO: begin
                    if (read) begin
                        next_s.readdata[7:0] = s.control2;
                    end else begin
                        next_s.control2 = writedata[7:0] & CTL2_IMPLEMENTED;
                    end
                end
                default: begin
                    next_s.readdata = 32'h0000_0000;
                end
            endcase
        end

        // Transfer engine
        unique case (s.engine)
            ENGINE_IDLE: begin
                next_s.sckLevel = next_s.control1[CTL1_CLOCK_POLARITY];
                if (enabled && isMaster && !s.transmitEmpty) begin
                    next_s = startByte(next_s);
                end else if (enabled && !isMaster && !selectSync) begin
                    next_s = startByte(next_s);
                end
            end
            ENGINE_RUN: begin
                if (!enabled || (!isMaster && selectSync)) begin
                    next_s.engine = ENGINE_IDLE;
                end else begin
                    if (isMaster) begin
                        if (s.divCount == HALF_CYCLES - 8'h01) begin
                            edgeNow = 1'b1;
                            leadNow = (s.sckLevel == cpol);
                            next_s.divCount = 8'h00;
                            next_s.sckLevel = !s.sckLevel;
                        end else begin
                            next_s.divCount = s.divCount + 8'h01;
                        end
                    end else begin
                        edgeNow = (sckSync != s.sckPrev);
                        leadNow = (sckSync != cpol);
                    end
                    if (edgeNow) begin
                        next_s.edgeCount = s.edgeCount + 4'h1;
                        if (leadNow != clock_phase) begin
                            next_s.sampled = 1'b1;
                            if (lsbFirst) begin
                                next_s.rxShift = {inBit, s.rxShift[7:1]};
                            end else begin
                                next_s.rxShift = {s.rxShift[6:0], inBit};
                            end
                        end else if (s.sampled) begin
                            if (lsbFirst) begin
                                next_s.txShift = {1'b0, s.txShift[7:1]};
                            end else begin
                                next_s.txShift = {s.txShift[6:0], 1'b0};
                            end
                        end
                        if (s.edgeCount == 4'(EDGES_PER_BYTE - 1)) begin
                            if (!s.receiveFull) begin
                                next_s.receiveBuffer = next_s.rxShift;
                            end
                            next_s.receiveFull = 1'b1;
                            next_s.engine = ENGINE_IDLE;
                            if (isMaster && !next_s.transmitEmpty) begin
                                next_s = startByte(next_s);
                            end
                        end
                    end
                end
            end
        endcase

        // Mode fault takes the port out of master mode
        if (enabled && faultInput && !selectSync) begin
            next_s.modeFault = 1'b1;
            next_s.control1[CTL1_MASTER_MODE] = 1'b0;
            next_s.engine = ENGINE_IDLE;
            next_s.sckLevel = next_s.control1[CTL1_CLOCK_POLARITY];
        end

        // Pin drive from the next state
        masterDrive = next_s.control1[CTL1_PORT_ENABLE] && next_s.control1[CTL1_MASTER_MODE];
        autoSelect = masterDrive && next_s.control2[CTL2_FAULT_DETECT]
            && next_s.control1[CTL1_SELECT_OUTPUT];
        txBit = next_s.control1[CTL1_BIT_ORDER] ? next_s.txShift[0] : next_s.txShift[7];
        next_s.sckOut = next_s.sckLevel;
        next_s.sckDriveN = !masterDrive;
        next_s.mosiOut = txBit;
        next_s.mosiDriveN = !masterDrive;
        next_s.misoOut = txBit;
        next_s.misoDriveN = !(next_s.control1[CTL1_PORT_ENABLE]
            && !next_s.control1[CTL1_MASTER_MODE] && !selectSync);
        next_s.ssOut = !(autoSelect && next_s.engine == ENGINE_RUN);
        next_s.ssDriveN = !autoSelect;

        // Interrupt request
        next_s.irq = ((next_s.receiveFull || next_s.modeFault)
            && next_s.control1[CTL1_RECEIVE_IRQ])
            || (next_s.transmitEmpty && next_s.control1[CTL1_TRANSMIT_IRQ]);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s <= STATE_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign readdata = s.readdata;
    assign waitrequest = s.waitrequest;
    assign irq = s.irq;
    assign serialClockOut = s.sckOut;
    assign serialClockDriveN = s.sckDriveN;
    assign mosiOut = s.mosiOut;
    assign mosiDriveN = s.mosiDriveN;
    assign misoOut = s.misoOut;
    assign misoDriveN = s.misoDriveN;
    assign selectOut = s.ssOut;
    assign selectDriveN = s.ssDriveN;
endmodule
`default_nettype wire

// ---- verif/spi_port_monitor.sv ----
// Bus and serial link checks for the serial port
`timescale 1ns/1ps
`default_nettype none
module spi_port_monitor
    import spi_port_pkg::*;
#(
    parameter logic [7:0] HALF_CYCLES = 8'(SCK_HALF_CYCLES)
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic serialClockOut,
    input wire logic serialClockDriveN,
    input wire logic mosiDriveN,
    input wire logic misoDriveN,
    input wire logic selectIn,
    input wire logic selectOut
);
    logic prevSel;
    logic prevSck;
    logic [7:0] edgeCount;
    // Counts clock edges inside one select window
    always_ff @(posedge clock) begin
        prevSel <= selectOut;
        prevSck <= serialClockOut;
        if (rst || (selectOut && prevSel)) begin
            edgeCount <= 8'h00;
        end else if (serialClockOut != prevSck) begin
            edgeCount <= edgeCount + 8'h01;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence busTaken;
        (read || write) && waitrequest;
    endsequence
    sequence frameStart;
        $fell(selectOut);
    endsequence
    take_answer_a: assert property (busTaken |=> !waitrequest)
        else $error("request not answered next cycle");
    answer_single_a: assert property (!waitrequest |=> waitrequest)
        else $error("answer held too long");
    status_unused_a: assert property (!waitrequest && read && address == ADDR_STATUS
        |-> readdata[6] == 1'b0 && readdata[3:0] == 4'h0) else $error("status spare bit set");
    upper_zero_a: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    frame_bounded_a: assert property (frameStart |-> ##[16:300] $rose(selectOut))
        else $error("frame length out of bounds");
    frame_edges_a: assert property ($rose(selectOut) |=> edgeCount[3:0] == 4'h0
        && edgeCount != 8'h00) else $error("frame edge count not whole bytes");
    drivers_paired_a: assert property (mosiDriveN == serialClockDriveN)
        else $error("data and clock drivers differ");
    slave_release_a: assert property (selectIn [*6] |=> misoDriveN)
        else $error("slave output driven while unselected");
endmodule
bind spi_port spi_port_monitor #(.HALF_CYCLES(HALF_CYCLES)) spi_port_monitor_inst (
    .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
    .readdata(readdata), .waitrequest(waitrequest), .serialClockOut(serialClockOut),
    .serialClockDriveN(serialClockDriveN), .mosiDriveN(mosiDriveN),
    .misoDriveN(misoDriveN), .selectIn(selectIn), .selectOut(selectOut));
`default_nettype wire

// ---- verif/spi_remote_slave.sv ----
// Remote slave: phase 0, polarity 0, msb first
`timescale 1ns/1ps
`default_nettype none
module spi_remote_slave (
    input wire logic serialClock,
    input wire logic dataIn,
    input wire logic selectN,
    input wire logic [7:0] loadByte,
    output logic dataOut,
    output logic [7:0] gotByte
);
    logic [7:0] shifter = 8'h00;
    logic [7:0] inBits = 8'h00;
    int bits = 0;
    int frames = 0;
    initial dataOut = 1'b1;
    initial gotByte = 8'h00;
    // Each frame sends the load byte xor the frame index
    task automatic reload();
        shifter = loadByte ^ 8'(frames);
        bits = 0;
        dataOut = shifter[7];
    endtask
    always @(negedge selectN) reload();
    always @(posedge selectN) dataOut = ~dataOut;
    always @(posedge serialClock) begin
        if (!selectN && bits < 8) begin
            inBits = {inBits[6:0], dataIn};
            bits++;
            if (bits == 8) begin
                gotByte = inBits;
                frames++;
            end
        end
    end
    always @(negedge serialClock) begin
        if (!selectN && bits == 8) begin
            reload();
        end else if (!selectN) begin
            shifter = shifter << 1;
            dataOut = shifter[7];
        end
    end
endmodule
`default_nettype wire

// ---- verif/tb_spi_port.sv ----
// Register-level bench for the serial port in master mode
`timescale 1ns/1ps
`default_nettype none
module tb_spi_port;
    import spi_port_pkg::*;
    logic clock, rst, read, write, selectIn, waitrequest, irq, sck, sckDrvN;
    logic mosi, mosiDrvN, miso, selOut, selDrvN;
    logic [3:0] address;
    logic [31:0] writedata, readdata, q;
    logic [7:0] slaveRx;
    int mismatches = 0;
    int n_tests = 0;
    int n;
    // Slower link so the synchronised input settles before each sample
    spi_port #(.HALF_CYCLES(8'h08)) spi_port_inst (.clock(clock), .rst(rst),
        .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .irq(irq), .serialClockIn(1'b0), .serialClockOut(sck), .serialClockDriveN(sckDrvN),
        .mosiIn(1'b0), .mosiOut(mosi), .mosiDriveN(mosiDrvN), .misoIn(miso), .misoOut(),
        .misoDriveN(), .selectIn(selectIn), .selectOut(selOut), .selectDriveN(selDrvN));
    spi_remote_slave spi_remote_slave_inst (.serialClock(sck), .dataIn(mosi),
        .selectN(selOut), .loadByte(8'h3c), .dataOut(miso), .gotByte(slaveRx));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic busOp(input logic isWrite, input logic [3:0] where, input logic [7:0] value);
        int k;
        k = 0;
        @(posedge clock);
        address <= where;
        writedata <= {24'h000000, value};
        read <= !isWrite;
        write <= isWrite;
        do begin
            @(posedge clock);
            k++;
        end while (waitrequest !== 1'b0 && k < 20);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (k >= 20) begin
            mismatches++;
            give_verdict();
        end
    endtask
    task automatic pollFull();
        q = 32'h0;
        n = 0;
        while (q[7] !== 1'b1) begin
            busOp(1'b0, ADDR_STATUS, 8'h00);
            n++;
            if (n > 100) begin
                mismatches++;
                give_verdict();
            end
        end
    endtask
    function automatic logic [7:0] rev(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            rev[i] = b[7 - i];
        end
    endfunction
    initial begin
        rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 4'h0;
        writedata = 32'h0;
        selectIn = 1'b1;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        busOp(1'b1, ADDR_DATA, 8'h77);
        busOp(1'b0, ADDR_STATUS, 8'h00); check(q, 32'h20);
        busOp(1'b0, ADDR_DATA, 8'h00); check(q, 32'h00);
        busOp(1'b0, 4'h1, 8'h00); check(q, 32'h00);
        busOp(1'b1, ADDR_STATUS, 8'hff);
        busOp(1'b0, ADDR_STATUS, 8'h00); check(q, 32'h20);
        $display("test reset done");
        busOp(1'b1, ADDR_CONTROL_TWO, 8'h10);
        busOp(1'b1, ADDR_CONTROL_ONE, 8'h52);
        check({30'h0, selDrvN, mosiDrvN}, 32'h0);
        busOp(1'b0, ADDR_STATUS, 8'h00);
        busOp(1'b1, ADDR_DATA, 8'ha5);
        busOp(1'b0, ADDR_STATUS, 8'h00); check(q, 32'h20);
        pollFull();
        check({24'h0, slaveRx}, 32'ha5);
        busOp(1'b0, ADDR_DATA, 8'h00); check(q, 32'h3c);
        busOp(1'b0, ADDR_STATUS, 8'h00); check(q, 32'h20);
        $display("test single byte done");
        busOp(1'b1, ADDR_DATA, 8'h11);
        busOp(1'b0, ADDR_STATUS, 8'h00); check(q, 32'h20);
        busOp(1'b1, ADDR_DATA, 8'h22);
        busOp(1'b0, ADDR_STATUS, 8'h00); check(q, 32'h00);
        pollFull();
        n = 0;
        while (slaveRx !== 8'h22 && n < 300) begin
            @(posedge clock);
            n++;
        end
        check({24'h0, slaveRx}, 32'h22);
        repeat (10) @(posedge clock);
        busOp(1'b0, ADDR_DATA, 8'h00); check(q, 32'h3d);
        busOp(1'b0, ADDR_STATUS, 8'h00); check(q, 32'h20);
        $display("test queued byte done");
        busOp(1'b1, ADDR_CONTROL_ONE, 8'h53);
        busOp(1'b0, ADDR_STATUS, 8'h00);
        busOp(1'b1, ADDR_DATA, 8'hc1);
        pollFull();
        check({24'h0, slaveRx}, {24'h0, rev(8'hc1)});
        busOp(1'b0, ADDR_DATA, 8'h00); check(q, {24'h0, rev(8'h3f)});
        $display("test lsb first done");
        busOp(1'b1, ADDR_CONTROL_ONE, 8'h60);
        repeat (3) @(posedge clock);
        check({31'h0, irq}, 32'h1);
        busOp(1'b1, ADDR_CONTROL_ONE, 8'h40);
        repeat (3) @(posedge clock);
        check({31'h0, irq}, 32'h0);
        $display("test interrupt done");
        busOp(1'b1, ADDR_CONTROL_TWO, 8'h10);
        busOp(1'b1, ADDR_CONTROL_ONE, 8'hd0);
        selectIn <= 1'b0;
        repeat (8) @(posedge clock);
        busOp(1'b0, ADDR_STATUS, 8'h00); check(q, 32'h30);
        busOp(1'b0, ADDR_CONTROL_ONE, 8'h00); check(q & 32'h10, 32'h0);
        check({30'h0, sckDrvN, mosiDrvN}, 32'h3);
        check({31'h0, irq}, 32'h1);
        selectIn <= 1'b1;
        repeat (8) @(posedge clock);
        busOp(1'b1, ADDR_CONTROL_ONE, 8'h40);
        busOp(1'b0, ADDR_STATUS, 8'h00); check(q, 32'h20);
        check({31'h0, irq}, 32'h0);
        $display("test mode fault done");
        give_verdict();
    end
endmodule
`default_nettype wire
